// ### logic/vtc_params.svh
// register offsets, field positions, reset values and counts for vtc
`ifndef VTC_PARAMS_SVH
`define VTC_PARAMS_SVH
`define VTC_OFS_ALEN_LO   8'h20
`define VTC_OFS_ALEN_HI   8'h21
`define VTC_OFS_VSIZE_LO  8'h24
`define VTC_OFS_VSIZE_HI  8'h25
`define VTC_OFS_DELAY_LO  8'h28
`define VTC_OFS_DELAY_HI  8'h29
`define VTC_OFS_HPW_LO    8'h2C
`define VTC_OFS_HPW_HI    8'h2D
`define VTC_OFS_VPW_LO    8'h30
`define VTC_OFS_VPW_HI    8'h31
`define VTC_OFS_CTRL      8'h3C
`define VTC_OFS_STATUS    8'h3D
`define VTC_CTRL_TP_BIT   4
`define VTC_RST_BYTE      8'h00
`define VTC_RST_NIB       4'h0
`define VTC_RST_TWO       2'h0
`define VTC_PIPE_LAT      13'h000A
`define VTC_MIN_DELAY     12'h020
`define VTC_FIFO_DEPTH    16
`define VTC_PIX_WIDTH     24
`endif

// ### logic/vtc_pkg.sv
// types shared by the video timing block
package vtc_pkg;
   typedef enum logic {
      VTC_NORMAL  = 1'b0,
      VTC_PATTERN = 1'b1
   } vtc_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } vtc_bus_t;

   typedef struct packed {
      logic        hs;
      logic        vs;
      logic        de;
      logic [23:0] data;
   } vtc_lvds_t;
endpackage

// ### logic/vtc_fifo.sv
// show-ahead flip-flop fifo with valid and ready on both sides
module vtc_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,   // system clock
   input  wire logic             rst_n,     // async reset
   input  wire logic             in_valid,  // write request
   output logic                  in_ready,  // room available
   input  wire logic [WIDTH-1:0] in_data,   // write word
   output logic                  out_valid, // word available
   input  wire logic             out_ready, // consumer takes word
   output logic [WIDTH-1:0]      out_data   // head word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign push       = in_valid && in_ready;
   assign pop        = out_valid && out_ready;
   assign out_data   = mem[rd_ptr];
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   // ==========================================================
   // storage
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // ==========================================================
   // pointers and flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count     <= next_count;
         in_ready  <= (next_count != (AW+1)'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end
endmodule

// ### logic/vtc_cha.sv
// video timing configuration and sync path for one lvds channel
//
// Overview of operation
// [RULE1] Active line length is 12 bits, low byte at 0x20, upper nibble at 0x21, shared by input and output.
// [RULE2] Vertical display size is 12 bits at 0x24/0x25 and is used only by the test pattern.
// [RULE3] Each received hsync or vsync is delayed by the 12-bit count at 0x28/0x29 in pixel clocks.
// [RULE4] A fixed latency of about 10 pixel clocks is added on top of the programmed sync delay.
// [RULE5] Software must program a sync delay of at least 32 pixel clocks.
// [RULE6] Hsync pulse width is 10 bits, low byte at 0x2C and bits 1:0 of 0x2D.
// [RULE7] Vsync pulse width in lines is 10 bits with its low byte at 0x30.
// [RULE8] Sync pulse widths time the test pattern while bit 4 of 0x3C is set.
// [RULE9] Pattern-only fields are ignored in normal video operation.
// [RULE10] Upper two bits of the vsync pulse width sit in bits 1:0 of 0x31.
// [RULE11] With bit 4 of 0x3C set, a test pattern is produced from the channel fields.
// [RULE12] All fields reset to zero, read back as written, and join upper and lower parts.
//
// Our own choice: strobed register access.
`include "vtc_params.svh"

module vtc_cha (
   input  wire logic              clk_sys,   // 50 MHz system clock
   input  wire logic              rst_n,     // async reset
   input  wire vtc_pkg::vtc_bus_t bus,       // register strobes
   output logic [7:0]             rd_data,   // read data, cycle after
   input  wire logic              pix_clk,   // lvds pixel clock pin
   input  wire logic              dsi_hsync, // received hsync level
   input  wire logic              dsi_vsync, // received vsync level
   input  wire logic              dsi_valid, // received pixel valid
   input  wire logic [23:0]       dsi_data,  // received pixel
   output logic                   dsi_ready, // pixel buffer has room
   output vtc_pkg::vtc_lvds_t     lvds       // lvds video output
);
   // ==========================================================
   // registers
   logic [7:0]         alen_lo;
   logic [3:0]         alen_hi;
   logic [7:0]         vsize_lo;
   logic [3:0]         vsize_hi;
   logic [7:0]         delay_lo;
   logic [3:0]         delay_hi;
   logic [7:0]         hpw_lo;
   logic [1:0]         hpw_hi;
   logic [7:0]         vpw_lo;
   logic [1:0]         vpw_hi;
   vtc_pkg::vtc_mode_t mode;
   logic [11:0]        alen;
   logic [11:0]        vsize;
   logic [11:0]        delay;
   logic [9:0]         hpw;
   logic [9:0]         vpw;
   logic [7:0]         next_rd;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // [RULE1] [RULE2] [RULE6] [RULE7] [RULE10] [RULE12] joined fields
   assign alen  = {alen_hi, alen_lo};
   assign vsize = {vsize_hi, vsize_lo};
   assign delay = {delay_hi, delay_lo};
   assign hpw   = {hpw_hi, hpw_lo};
   assign vpw   = {vpw_hi, vpw_lo};

   // [RULE12] register writes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         alen_lo  <= `VTC_RST_BYTE;
         alen_hi  <= `VTC_RST_NIB;
         vsize_lo <= `VTC_RST_BYTE;
         vsize_hi <= `VTC_RST_NIB;
         delay_lo <= `VTC_RST_BYTE;
         delay_hi <= `VTC_RST_NIB;
         hpw_lo   <= `VTC_RST_BYTE;
         hpw_hi   <= `VTC_RST_TWO;
         vpw_lo   <= `VTC_RST_BYTE;
         vpw_hi   <= `VTC_RST_TWO;
         mode     <= vtc_pkg::VTC_NORMAL;
      end else if (bus.wr) begin
         case (bus.addr)
            `VTC_OFS_ALEN_LO:  alen_lo  <= bus.wdata;
            `VTC_OFS_ALEN_HI:  alen_hi  <= bus.wdata[3:0];
            `VTC_OFS_VSIZE_LO: vsize_lo <= bus.wdata;
            `VTC_OFS_VSIZE_HI: vsize_hi <= bus.wdata[3:0];
            `VTC_OFS_DELAY_LO: delay_lo <= bus.wdata;
            `VTC_OFS_DELAY_HI: delay_hi <= bus.wdata[3:0];
            `VTC_OFS_HPW_LO:   hpw_lo   <= bus.wdata;
            `VTC_OFS_HPW_HI:   hpw_hi   <= bus.wdata[1:0];
            `VTC_OFS_VPW_LO:   vpw_lo   <= bus.wdata;
            `VTC_OFS_VPW_HI:   vpw_hi   <= bus.wdata[1:0];
            `VTC_OFS_CTRL: begin
               mode <= vtc_pkg::vtc_mode_t'(bus.wdata[`VTC_CTRL_TP_BIT]);
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // read path
   logic fifo_full;
   logic fifo_empty;
   logic low_delay;

   // [RULE5] flag a delay below the safe floor
   assign low_delay = (delay < `VTC_MIN_DELAY);

   always_comb begin
      next_rd = 8'h00;
      case (bus.addr)
         `VTC_OFS_ALEN_LO:  next_rd = alen_lo;
         `VTC_OFS_ALEN_HI:  next_rd = {4'h0, alen_hi};
         `VTC_OFS_VSIZE_LO: next_rd = vsize_lo;
         `VTC_OFS_VSIZE_HI: next_rd = {4'h0, vsize_hi};
         `VTC_OFS_DELAY_LO: next_rd = delay_lo;
         `VTC_OFS_DELAY_HI: next_rd = {4'h0, delay_hi};
         `VTC_OFS_HPW_LO:   next_rd = hpw_lo;
         `VTC_OFS_HPW_HI:   next_rd = {6'h00, hpw_hi};
         `VTC_OFS_VPW_LO:   next_rd = vpw_lo;
         `VTC_OFS_VPW_HI:   next_rd = {6'h00, vpw_hi};
         `VTC_OFS_CTRL:     next_rd = {3'h0, mode, 4'h0};
         `VTC_OFS_STATUS: begin
            next_rd = {4'h0, low_delay, mode, fifo_empty, fifo_full};
         end
         default:           next_rd = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= bus.rd ? next_rd : 8'h00;
      end
   end

   // ==========================================================
   // pin synchronisers: pixel clock and the two syncs
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_lvl;
   logic [2:0] pin_lvl_d;
   logic       pix_tick;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1    <= 3'h0;
         pin_s2    <= 3'h0;
         pin_s3    <= 3'h0;
         pin_lvl   <= 3'h0;
         pin_lvl_d <= 3'h0;
      end else begin
         pin_s1    <= {dsi_vsync, dsi_hsync, pix_clk};
         pin_s2    <= pin_s1;
         pin_s3    <= pin_s2;
         pin_lvl   <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
         pin_lvl_d <= pin_lvl;
      end
   end

   assign pix_tick = pin_lvl[0] && !pin_lvl_d[0];

   // ==========================================================
   // sync delay: one countdown per edge of each sync
   logic [3:0] edge_seen;
   logic [3:0] fire;
   logic [1:0] dly_lvl;
   logic [3:0] busy;
   logic [12:0] cnt [4];
   logic [12:0] dly_load;

   // [RULE4] programmed count plus fixed pipeline latency
   assign dly_load = {1'b0, delay} + `VTC_PIPE_LAT;

   genvar e;
   generate
      for (e = 0; e < 4; e++) begin : g_edge
         // even channel: rising edge, odd channel: falling edge
         assign edge_seen[e] = (e % 2 == 0)
            ? (pin_lvl[1+e/2] && !pin_lvl_d[1+e/2])
            : (!pin_lvl[1+e/2] && pin_lvl_d[1+e/2]);
         assign fire[e] = busy[e] && pix_tick && (cnt[e] == 13'h0001);

         // [RULE3] load and count the sync delay
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               busy[e] <= 1'b0;
               cnt[e]  <= 13'h0000;
            end else if (edge_seen[e]) begin
               busy[e] <= 1'b1;
               cnt[e]  <= dly_load;
            end else if (busy[e] && pix_tick) begin
               busy[e] <= (cnt[e] != 13'h0001);
               cnt[e]  <= cnt[e] - 13'h0001;
            end
         end

         a_delay_load: assert property ( // [RULE3]
            edge_seen[e] |=> busy[e] && cnt[e] == $past(dly_load))
            else $error("sync delay count not loaded");
         a_delay_floor: assert property ( // [RULE4]
            edge_seen[e] |=> cnt[e] >= 13'h000A)
            else $error("pipeline latency missing");
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dly_lvl <= 2'h0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            if (fire[2*s]) begin
               dly_lvl[s] <= 1'b1;
            end else if (fire[2*s+1]) begin
               dly_lvl[s] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // pixel buffer and normal line gating
   logic        pop;
   logic        head_valid;
   logic [23:0] head;
   logic        run;
   logic [11:0] px_cnt;
   logic        hs_end;

   assign pop    = pix_tick && run && (mode == vtc_pkg::VTC_NORMAL);
   assign hs_end = fire[1];

   vtc_fifo #(
      .WIDTH (`VTC_PIX_WIDTH),
      .DEPTH (`VTC_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (dsi_valid),
      .in_ready  (dsi_ready),
      .in_data   (dsi_data),
      .out_valid (head_valid),
      .out_ready (pop),
      .out_data  (head)
   );

   assign fifo_full  = !dsi_ready;
   assign fifo_empty = !head_valid;

   // [RULE1] one line of alen pixels after each delayed hsync
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run    <= 1'b0;
         px_cnt <= 12'h000;
      end else if (hs_end && alen != 12'h000) begin
         run    <= 1'b1;
         px_cnt <= alen;
      end else if (pop) begin
         run    <= (px_cnt != 12'h001);
         px_cnt <= px_cnt - 12'h001;
      end
   end

   // ==========================================================
   // test pattern counters
   logic [12:0] htotal;
   logic [12:0] vtotal;
   logic [12:0] h_cnt;
   logic [12:0] v_cnt;
   logic        tp_hs;
   logic        tp_vs;
   logic        tp_de;

   // [RULE11] pattern frame built from the channel fields
   assign htotal = {3'h0, hpw} + {1'b0, alen};
   assign vtotal = {3'h0, vpw} + {1'b0, vsize};
   // [RULE8] pulse widths shape the pattern syncs
   assign tp_hs  = h_cnt < {3'h0, hpw};
   assign tp_vs  = v_cnt < {3'h0, vpw};
   assign tp_de  = !tp_hs && !tp_vs && h_cnt < htotal && v_cnt < vtotal;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         h_cnt <= 13'h0000;
         v_cnt <= 13'h0000;
      end else if (mode == vtc_pkg::VTC_NORMAL) begin
         h_cnt <= 13'h0000;
         v_cnt <= 13'h0000;
      end else if (pix_tick) begin
         if (h_cnt + 13'h0001 >= htotal) begin
            h_cnt <= 13'h0000;
            v_cnt <= (v_cnt + 13'h0001 >= vtotal) ? 13'h0000
                                                  : v_cnt + 13'h0001;
         end else begin
            h_cnt <= h_cnt + 13'h0001;
         end
      end
   end

   // ==========================================================
   // output register, updated once per pixel clock
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lvds <= '0;
      end else if (pix_tick) begin
         unique case (mode)
            // [RULE9] normal path ignores pattern-only fields
            vtc_pkg::VTC_NORMAL: begin
               lvds.hs   <= dly_lvl[0];
               lvds.vs   <= dly_lvl[1];
               lvds.de   <= run;
               lvds.data <= (run && head_valid) ? head : 24'h00_0000;
            end
            // [RULE11] pattern: colour ramps from the counters
            vtc_pkg::VTC_PATTERN: begin
               lvds.hs   <= tp_hs;
               lvds.vs   <= tp_vs;
               lvds.de   <= tp_de;
               lvds.data <= tp_de ? {h_cnt[7:0], v_cnt[7:0], h_cnt[11:4]}
                                  : 24'h00_0000;
            end
         endcase
      end
   end

   // ==========================================================
   // assertions
   a_alen_write: assert property ( // [RULE1]
      bus.wr && bus.addr == `VTC_OFS_ALEN_HI
      |=> alen[11:8] == $past(bus.wdata[3:0]))
      else $error("line length upper nibble not taken");
   a_vsize_write: assert property ( // [RULE2]
      bus.wr && bus.addr == `VTC_OFS_VSIZE_LO
      |=> vsize[7:0] == $past(bus.wdata))
      else $error("display size low byte not taken");
   a_hpw_write: assert property ( // [RULE6]
      bus.wr && bus.addr == `VTC_OFS_HPW_HI
      |=> hpw[9:8] == $past(bus.wdata[1:0]))
      else $error("hsync width upper bits not taken");
   a_vpw_write: assert property ( // [RULE7]
      bus.wr && bus.addr == `VTC_OFS_VPW_LO
      |=> vpw[7:0] == $past(bus.wdata))
      else $error("vsync width low byte not taken");
   a_vpw_upper: assert property ( // [RULE10]
      bus.wr && bus.addr == `VTC_OFS_VPW_HI
      |=> vpw[9:8] == $past(bus.wdata[1:0]))
      else $error("vsync width upper bits not taken");
   a_tp_hs_width: assert property ( // [RULE8]
      mode == vtc_pkg::VTC_PATTERN && pix_tick && $stable(mode)
      |=> lvds.hs == ($past(h_cnt) < {3'h0, $past(hpw)}))
      else $error("pattern hsync width wrong");
   a_normal_sync: assert property ( // [RULE9]
      mode == vtc_pkg::VTC_NORMAL && pix_tick
      |=> lvds.hs == $past(dly_lvl[0]) && lvds.vs == $past(dly_lvl[1]))
      else $error("normal sync not from delayed input");
   a_tp_de: assert property ( // [RULE11]
      mode == vtc_pkg::VTC_PATTERN && pix_tick
      |=> lvds.de == $past(tp_de))
      else $error("pattern enable wrong");
   a_read_back: assert property ( // [RULE12]
      bus.rd && bus.addr == `VTC_OFS_DELAY_LO
      |=> rd_data == $past(delay_lo) ##1 rd_data == 8'h00 || $past(bus.rd))
      else $error("read data not as written");

   c_sync_fire:  cover property (fire[0] ##[1:300] fire[1]);
   c_line_run:   cover property ($rose(run) ##[1:1000] $fell(run));
   c_pattern_de: cover property (mode == vtc_pkg::VTC_PATTERN
                                 && $rose(lvds.de));
endmodule

// ### verification/vtc_far_end.sv
// far-end model: dsi video host and lvds panel around one channel
module vtc_far_end (
   input  wire logic               clk_sys,   // system clock
   input  wire logic               dsi_ready, // channel has room
   input  wire vtc_pkg::vtc_lvds_t lvds,      // channel video out
   output logic                    dsi_hsync, // host hsync
   output logic                    dsi_vsync, // host vsync
   output logic                    dsi_valid, // host word valid
   output logic [23:0]             dsi_data   // host word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] got [$];
   logic        de_q;
   logic [23:0] data_q;
   initial begin
      dsi_hsync = 1'b0;
      dsi_vsync = 1'b0;
      dsi_valid = 1'b0;
      dsi_data  = 24'h00_0000;
      de_q      = 1'b0;
      data_q    = 24'h00_0000;
   end
   // ==========
   // host side
   // a word stands until taken, then the lines flip so nothing stale shows
   task automatic send_word(input logic [23:0] d);
      @(posedge clk_sys);
      dsi_valid <= 1'b1;
      dsi_data  <= d;
      do
         @(posedge clk_sys);
      while (dsi_ready !== 1'b1);
      dsi_valid <= 1'b0;
      dsi_data  <= ~d;
   endtask
   task automatic set_sync(input int sel, input logic lvl);
      @(posedge clk_sys);
      if (sel == 0) begin
         dsi_hsync <= lvl;
      end else begin
         dsi_vsync <= lvl;
      end
   endtask
   // ==========
   // panel side: one entry per new active word
   always @(posedge clk_sys) begin
      if (lvds.de === 1'b1 && (de_q !== 1'b1 || lvds.data !== data_q)) begin
         got.push_back(lvds.data);
      end
      de_q   <= lvds.de;
      data_q <= lvds.data;
   end
endmodule

// ### verification/vtc_cha_bench.sv
// self-checking bench for the channel video timing block
`include "vtc_params.svh"
module vtc_cha_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] OFS [10] = '{`VTC_OFS_ALEN_LO, `VTC_OFS_ALEN_HI,
      `VTC_OFS_VSIZE_LO, `VTC_OFS_VSIZE_HI, `VTC_OFS_DELAY_LO,
      `VTC_OFS_DELAY_HI, `VTC_OFS_HPW_LO, `VTC_OFS_HPW_HI,
      `VTC_OFS_VPW_LO, `VTC_OFS_VPW_HI};
   localparam logic [7:0] MSK [10] = '{8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF,
      8'h0F, 8'hFF, 8'h03, 8'hFF, 8'h03};
   logic               clk_sys;
   logic               rst_n;
   logic               pix_clk;
   vtc_pkg::vtc_bus_t  bus;
   logic [7:0]         rd_data;
   logic               dsi_hsync;
   logic               dsi_vsync;
   logic               dsi_valid;
   logic [23:0]        dsi_data;
   logic               dsi_ready;
   vtc_pkg::vtc_lvds_t lvds;
   int                 n_fail;
   int                 n_checks;
   int                 seed;
   int                 tick_n;
   int                 cyc;

   vtc_cha i_vtc_cha (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus),
      .rd_data(rd_data), .pix_clk(pix_clk), .dsi_hsync(dsi_hsync),
      .dsi_vsync(dsi_vsync), .dsi_valid(dsi_valid), .dsi_data(dsi_data),
      .dsi_ready(dsi_ready), .lvds(lvds));
   vtc_far_end i_vtc_far_end (.clk_sys(clk_sys), .dsi_ready(dsi_ready),
      .lvds(lvds), .dsi_hsync(dsi_hsync), .dsi_vsync(dsi_vsync),
      .dsi_valid(dsi_valid), .dsi_data(dsi_data));

   // ==========
   // clocks and watchdog
   initial clk_sys = 1'b0;
   always #10 clk_sys = ~clk_sys;
   initial begin
      pix_clk = 1'b0;
      tick_n  = 0;
      cyc     = 0;
      #7;
      forever #80 pix_clk = ~pix_clk;
   end
   always @(posedge pix_clk) tick_n++;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         $display("MISMATCH %0t run did not finish", $time);
         wrap_up();
      end
   end

   // ==========
   // tasks
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_span(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("MISMATCH %0t span %0d not in %0d..%0d", $time, got, lo,
                  hi);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1;
      d = rd_data;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      reg_rd(a, v);
      chk(24'(v), 24'(e));
   endtask
   function automatic logic lv(input int sel);
      if (sel == 0) return lvds.hs;
      if (sel == 1) return lvds.vs;
      return lvds.de;
   endfunction
   task automatic wait_lvl(input int sel, input logic lvl, output int t);
      int n;
      n = 0;
      while (lv(sel) !== lvl && n < 12000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(24'(lv(sel)), 24'(lvl));
      t = tick_n;
   endtask
   // width and period of an output pulse, in pixel ticks
   task automatic edges(input int sel, output int w, output int p);
      int x, a, b, c;
      wait_lvl(sel, 1'b0, x);
      wait_lvl(sel, 1'b1, a);
      wait_lvl(sel, 1'b0, b);
      wait_lvl(sel, 1'b1, c);
      w = b - a;
      p = c - a;
   endtask
   task automatic sync_case(input int sel, input int d, input int w);
      int t0, t1, t2;
      reg_wr(`VTC_OFS_DELAY_LO, d[7:0]);
      reg_wr(`VTC_OFS_DELAY_HI, {4'h0, d[11:8]});
      @(posedge pix_clk);
      #1;
      t0 = tick_n;
      i_vtc_far_end.set_sync(sel, 1'b1);
      repeat (w) @(posedge pix_clk);
      i_vtc_far_end.set_sync(sel, 1'b0);
      wait_lvl(sel, 1'b1, t1);
      wait_lvl(sel, 1'b0, t2);
      chk_span(t1 - t0, d + 10, d + 12);
      chk_span(t2 - t1, w - 1, w + 1);
   endtask
   task automatic tp_cfg(input int hpw, input int vpw);
      reg_wr(`VTC_OFS_CTRL, 8'h00);
      reg_wr(`VTC_OFS_ALEN_LO, 8'h03);
      reg_wr(`VTC_OFS_ALEN_HI, 8'h00);
      reg_wr(`VTC_OFS_VSIZE_LO, 8'h02);
      reg_wr(`VTC_OFS_VSIZE_HI, 8'h00);
      reg_wr(`VTC_OFS_HPW_LO, hpw[7:0]);
      reg_wr(`VTC_OFS_HPW_HI, {6'h00, hpw[9:8]});
      reg_wr(`VTC_OFS_VPW_LO, vpw[7:0]);
      reg_wr(`VTC_OFS_VPW_HI, {6'h00, vpw[9:8]});
      reg_wr(`VTC_OFS_CTRL, 8'h10);
   endtask

   // ==========
   // main sequence
   initial begin
      int          i, cnt, w, p;
      logic [7:0]  v;
      logic [7:0]  exp_r [10];
      logic [23:0] d;
      logic [23:0] sent [$];
      seed     = 32;
      n_fail   = 0;
      n_checks = 0;
      rst_n    = 1'b0;
      bus      = '0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (i = 0; i < 10; i++) reg_chk(OFS[i], 8'h00);
      reg_chk(`VTC_OFS_CTRL, 8'h00);
      reg_chk(`VTC_OFS_STATUS, 8'h0A);
      reg_wr(8'h22, 8'hA5);
      reg_chk(8'h22, 8'h00);
      $display("test reset values done");
      repeat (3) begin
         for (i = 0; i < 10; i++) begin
            v = 8'($random(seed));
            reg_wr(OFS[i], v);
            exp_r[i] = v & MSK[i];
         end
         for (i = 0; i < 10; i++) reg_chk(OFS[i], exp_r[i]);
      end
      repeat (20) @(posedge pix_clk);
      #1;
      chk(24'({lvds.hs, lvds.vs, lvds.de}), 24'h00_0000);
      $display("test read back done");
      reg_wr(`VTC_OFS_ALEN_LO, 8'h10);
      reg_wr(`VTC_OFS_ALEN_HI, 8'h00);
      cnt = 0;
      while (dsi_ready === 1'b1 && cnt < 20) begin
         d = 24'($random(seed));
         d[3:0] = 4'(cnt);
         sent.push_back(d);
         i_vtc_far_end.send_word(d);
         repeat (1 + {$random(seed)} % 3) @(posedge clk_sys);
         #1;
         cnt++;
      end
      chk_span(cnt, 16, 16);
      reg_rd(`VTC_OFS_STATUS, v);
      chk(24'(v[0]), 24'h00_0001);
      sync_case(0, 32, 5);
      cnt = 0;
      while (i_vtc_far_end.got.size() < 16 && cnt < 400) begin
         @(posedge clk_sys);
         cnt++;
      end
      chk_span(i_vtc_far_end.got.size(), 16, 16);
      for (i = 0; i < 16; i++) chk(i_vtc_far_end.got[i], sent[i]);
      reg_rd(`VTC_OFS_STATUS, v);
      chk(24'(v[1]), 24'h00_0001);
      chk(24'(v[3]), 24'h00_0000);
      sync_case(1, 33 + {$random(seed)} % 64, 3);
      $display("test sync path done");
      tp_cfg(2, 1);
      reg_rd(`VTC_OFS_STATUS, v);
      chk(24'(v[2]), 24'h00_0001);
      edges(0, w, p);
      chk_span(w, 2, 2);
      chk_span(p, 5, 5);
      edges(2, w, p);
      chk_span(w, 3, 3);
      // first active pattern pixel of a line sits at column 2
      chk(24'({lvds.data[23:16], lvds.data[7:0]}), 24'h00_0200);
      edges(1, w, p);
      chk_span(w, 5, 5);
      chk_span(p, 15, 15);
      tp_cfg(257, 1);
      edges(0, w, p);
      chk_span(w, 257, 257);
      tp_cfg(2, 257);
      edges(1, w, p);
      chk_span(w, 1285, 1285);
      chk_span(p, 1295, 1295);
      reg_wr(`VTC_OFS_CTRL, 8'h00);
      repeat (20) @(posedge pix_clk);
      #1;
      chk(24'({lvds.hs, lvds.vs, lvds.de}), 24'h00_0000);
      $display("test pattern done");
      wrap_up();
   end
endmodule
